// ### ifd_decoder.v
`timescale 1ns/10ps
`include "ifd_defines.vh"

// Overview of operation
// - every instruction is one 16-bit word; opcode bits select operand meaning.
// - fields are opcode, source, destination, immediate and displacement; immediate and displacement share the register field bits.
// - long branch: top nibble opcode, twelve bits PC-relative displacement.
// - 8-bit displacement layout: base-pointer-relative source or destination, other is index zero.
// - same layout also gives PC-relative load of index zero and PC-relative branch.
// - multiply-accumulate: both fields post-increment sources, result to accumulator pair.
// - single-source layout: branch to PC plus source register.
// - single-source layout: jump through source register, no destination.
// - two-register layout: destination address is destination plus index zero.
// - two-register layout: destination indirect, source register direct data.
// - single-register layouts allow control/system register as other operand, with pre-decrement/post-increment.
// - register and base-pointer displacements zero-extend, then scale by 1, 2 or 4.
// - PC-relative branch displacements of 8 or 12 bits sign-extend and double.
// - trap immediate zero-extends times four; test zero-extends; move/add/compare sign-extend.

module ifd_decoder (
  input wire clk_sys,
  input wire rst_n,
  input wire instr_valid,
  input wire [15:0] instr_word,
  output reg [3:0] dec_format,
  output reg [3:0] dec_src_mode,
  output reg [3:0] dec_dst_mode,
  output wire [3:0] source_reg_field,
  output wire [3:0] destination_reg_field,
  output wire [31:0] dec_const,
  output reg [1:0] dec_size,
  output reg dec_illegal,
  output reg dec_valid_reg,
  output reg [3:0] dec_format_reg,
  output reg [3:0] dec_src_mode_reg,
  output reg [3:0] dec_dst_mode_reg,
  output reg [3:0] dec_src_idx_reg,
  output reg [3:0] dec_dst_idx_reg,
  output reg [31:0] dec_const_reg,
  output reg [1:0] dec_size_reg,
  output reg dec_illegal_reg
);

  reg [2:0] ext_kind;
  reg [1:0] scale_shift;

  wire [3:0] op_nib;
  wire [3:0] n_nib;
  wire [3:0] m_nib;
  wire [3:0] low_nib;

  assign op_nib = instr_word[`IFD_OP_MSB:`IFD_OP_LSB];
  assign n_nib = instr_word[`IFD_DST_MSB:`IFD_DST_LSB];
  assign m_nib = instr_word[`IFD_SRC_MSB:`IFD_SRC_LSB];
  assign low_nib = instr_word[`IFD_LOW_MSB:`IFD_LOW_LSB];

  // size held in the two low bits of a move sub-opcode; 2'h3 reads as long
  function [1:0] size_of;
    input [1:0] code;
    begin
      size_of = (code == 2'h3) ? `IFD_SIZE_LONG : code;
    end
  endfunction

  always @* begin
    dec_format = `IFD_FMT_BAD;
    dec_src_mode = `IFD_MODE_NONE;
    dec_dst_mode = `IFD_MODE_NONE;
    dec_size = `IFD_SIZE_LONG;
    dec_illegal = 1'b0;
    ext_kind = `IFD_EXT_NONE;
    scale_shift = 2'h0;
    case (op_nib)
      4'h0: begin
        case (low_nib)
          4'h4, 4'h5, 4'h6: begin
            dec_format = `IFD_FMT_NM;
            dec_src_mode = `IFD_MODE_REG;
            dec_dst_mode = `IFD_MODE_IDX_R0;
            dec_size = size_of(low_nib[1:0]);
          end
          4'h7: begin
            dec_format = `IFD_FMT_NM;
            dec_src_mode = `IFD_MODE_REG;
            dec_dst_mode = `IFD_MODE_MAC_ACC;
          end
          4'hC, 4'hD, 4'hE: begin
            dec_format = `IFD_FMT_NM;
            dec_src_mode = `IFD_MODE_IDX_R0;
            dec_dst_mode = `IFD_MODE_REG;
            dec_size = size_of(low_nib[1:0]);
          end
          4'hF: begin
            dec_format = `IFD_FMT_NM;
            dec_src_mode = `IFD_MODE_POSTINC;
            dec_dst_mode = `IFD_MODE_MAC_ACC;
          end
          4'h2, 4'hA: begin
            if (m_nib <= 4'h2) begin
              dec_format = `IFD_FMT_N;
              dec_src_mode = `IFD_MODE_CTRL_SYS;
              dec_dst_mode = `IFD_MODE_REG;
            end else begin
              dec_illegal = 1'b1;
            end
          end
          4'h3: begin
            if (m_nib == 4'h0 || m_nib == 4'h2) begin
              dec_format = `IFD_FMT_M;
              dec_src_mode = `IFD_MODE_PC_PLUS_REG;
            end else begin
              dec_illegal = 1'b1;
            end
          end
          4'h9: begin
            if (m_nib == 4'h2) begin
              dec_format = `IFD_FMT_N;
              dec_dst_mode = `IFD_MODE_REG;
            end else if (m_nib <= 4'h1 && n_nib == 4'h0) begin
              dec_format = `IFD_FMT_ZERO;
            end else begin
              dec_illegal = 1'b1;
            end
          end
          4'h8, 4'hB: begin
            if (m_nib <= 4'h2 && n_nib == 4'h0) begin
              dec_format = `IFD_FMT_ZERO;
            end else begin
              dec_illegal = 1'b1;
            end
          end
          default: begin
            dec_illegal = 1'b1;
          end
        endcase
      end
      4'h1: begin
        dec_format = `IFD_FMT_NMD;
        dec_src_mode = `IFD_MODE_REG;
        dec_dst_mode = `IFD_MODE_REG_DISP;
        ext_kind = `IFD_EXT_Z4;
        scale_shift = `IFD_SIZE_LONG;
      end
      4'h2: begin
        dec_format = `IFD_FMT_NM;
        dec_src_mode = `IFD_MODE_REG;
        dec_dst_mode = `IFD_MODE_REG;
        if (low_nib <= 4'h2) begin
          dec_dst_mode = `IFD_MODE_IND;
          dec_size = size_of(low_nib[1:0]);
        end else if (low_nib == 4'h3) begin
          dec_format = `IFD_FMT_BAD;
          dec_src_mode = `IFD_MODE_NONE;
          dec_dst_mode = `IFD_MODE_NONE;
          dec_illegal = 1'b1;
        end else if (low_nib <= 4'h6) begin
          dec_dst_mode = `IFD_MODE_PREDEC;
          dec_size = size_of(low_nib[1:0]);
        end
      end
      4'h3: begin
        dec_format = `IFD_FMT_NM;
        dec_src_mode = `IFD_MODE_REG;
        dec_dst_mode = `IFD_MODE_REG;
      end
      4'h4: begin
        if (low_nib == 4'hF) begin
          dec_format = `IFD_FMT_NM;
          dec_src_mode = `IFD_MODE_POSTINC;
          dec_dst_mode = `IFD_MODE_MAC_ACC;
          dec_size = `IFD_SIZE_WORD;
        end else begin
          case (low_nib)
            4'h2, 4'h3: begin
              dec_format = `IFD_FMT_N;
              dec_src_mode = `IFD_MODE_CTRL_SYS;
              dec_dst_mode = `IFD_MODE_PREDEC;
            end
            4'h6, 4'h7: begin
              dec_format = `IFD_FMT_M;
              dec_src_mode = `IFD_MODE_POSTINC;
              dec_dst_mode = `IFD_MODE_CTRL_SYS;
            end
            4'hA, 4'hE: begin
              dec_format = `IFD_FMT_M;
              dec_src_mode = `IFD_MODE_REG;
              dec_dst_mode = `IFD_MODE_CTRL_SYS;
            end
            4'hB: begin
              if (m_nib == 4'h1) begin
                dec_format = `IFD_FMT_N;
                dec_dst_mode = `IFD_MODE_IND;
                dec_size = `IFD_SIZE_BYTE;
              end else begin
                dec_format = `IFD_FMT_M;
                dec_src_mode = `IFD_MODE_IND;
              end
            end
            default: begin
              dec_format = `IFD_FMT_N;
              dec_dst_mode = `IFD_MODE_REG;
            end
          endcase
        end
      end
      4'h5: begin
        dec_format = `IFD_FMT_NMD;
        dec_src_mode = `IFD_MODE_REG_DISP;
        dec_dst_mode = `IFD_MODE_REG;
        ext_kind = `IFD_EXT_Z4;
        scale_shift = `IFD_SIZE_LONG;
      end
      4'h6: begin
        dec_format = `IFD_FMT_NM;
        dec_src_mode = `IFD_MODE_REG;
        dec_dst_mode = `IFD_MODE_REG;
        if (low_nib <= 4'h2) begin
          dec_src_mode = `IFD_MODE_IND;
          dec_size = size_of(low_nib[1:0]);
        end else if (low_nib >= 4'h4 && low_nib <= 4'h6) begin
          dec_src_mode = `IFD_MODE_POSTINC;
          dec_size = size_of(low_nib[1:0]);
        end
      end
      4'h7, 4'hE: begin
        dec_format = `IFD_FMT_NI;
        dec_src_mode = `IFD_MODE_IMM;
        dec_dst_mode = `IFD_MODE_REG;
        ext_kind = `IFD_EXT_S8;
      end
      4'h8: begin
        case (n_nib)
          4'h0, 4'h1: begin
            dec_format = `IFD_FMT_ND4;
            dec_src_mode = `IFD_MODE_R0;
            dec_dst_mode = `IFD_MODE_REG_DISP;
            dec_size = n_nib[1:0];
            ext_kind = `IFD_EXT_Z4;
            scale_shift = n_nib[1:0];
          end
          4'h4, 4'h5: begin
            dec_format = `IFD_FMT_MD;
            dec_src_mode = `IFD_MODE_REG_DISP;
            dec_dst_mode = `IFD_MODE_R0;
            dec_size = {1'b0, n_nib[0]};
            ext_kind = `IFD_EXT_Z4;
            scale_shift = {1'b0, n_nib[0]};
          end
          4'h8: begin
            dec_format = `IFD_FMT_I;
            dec_src_mode = `IFD_MODE_IMM;
            dec_dst_mode = `IFD_MODE_R0;
            ext_kind = `IFD_EXT_S8;
          end
          4'h9, 4'hB, 4'hD, 4'hF: begin
            dec_format = `IFD_FMT_D;
            dec_dst_mode = `IFD_MODE_PC_REL;
            ext_kind = `IFD_EXT_S8;
            scale_shift = 2'h1;
          end
          default: begin
            dec_illegal = 1'b1;
          end
        endcase
      end
      4'h9, 4'hD: begin
        dec_format = `IFD_FMT_ND8;
        dec_src_mode = `IFD_MODE_PC_DISP;
        dec_dst_mode = `IFD_MODE_REG;
        dec_size = op_nib[2] ? `IFD_SIZE_LONG : `IFD_SIZE_WORD;
        ext_kind = `IFD_EXT_Z8;
        scale_shift = op_nib[2] ? 2'h2 : 2'h1;
      end
      4'hA, 4'hB: begin
        dec_format = `IFD_FMT_D12;
        dec_dst_mode = `IFD_MODE_PC_REL;
        ext_kind = `IFD_EXT_S12;
        scale_shift = 2'h1;
      end
      4'hC: begin
        dec_format = `IFD_FMT_D;
        dec_size = n_nib[1:0];
        if (n_nib <= 4'h2) begin
          dec_src_mode = `IFD_MODE_R0;
          dec_dst_mode = `IFD_MODE_GBR_DISP;
          ext_kind = `IFD_EXT_Z8;
          scale_shift = n_nib[1:0];
        end else if (n_nib == 4'h3) begin
          dec_format = `IFD_FMT_I;
          dec_src_mode = `IFD_MODE_IMM;
          dec_size = `IFD_SIZE_LONG;
          ext_kind = `IFD_EXT_Z8;
          scale_shift = 2'h2;
        end else if (n_nib <= 4'h6) begin
          dec_src_mode = `IFD_MODE_GBR_DISP;
          dec_dst_mode = `IFD_MODE_R0;
          dec_size = size_of(n_nib[1:0] - 2'h0);
          ext_kind = `IFD_EXT_Z8;
          scale_shift = size_of(n_nib[1:0]);
        end else if (n_nib == 4'h7) begin
          dec_src_mode = `IFD_MODE_PC_DISP;
          dec_dst_mode = `IFD_MODE_R0;
          dec_size = `IFD_SIZE_LONG;
          ext_kind = `IFD_EXT_Z8;
          scale_shift = 2'h2;
        end else begin
          // test immediates zero-extend; byte forms act through index plus base pointer
          dec_format = `IFD_FMT_I;
          dec_src_mode = `IFD_MODE_IMM;
          dec_dst_mode = n_nib[2] ? `IFD_MODE_IDX_GBR : `IFD_MODE_R0;
          dec_size = n_nib[2] ? `IFD_SIZE_BYTE : `IFD_SIZE_LONG;
          ext_kind = `IFD_EXT_Z8;
        end
      end
      default: begin
        dec_illegal = 1'b1;
      end
    endcase
  end

  ifd_field_extract u_fields (
    .instr_word(instr_word),
    .fmt(dec_format),
    .destination_reg_field(destination_reg_field),
    .source_reg_field(source_reg_field)
  );

  ifd_disp_extend u_extend (
    .instr_word(instr_word),
    .ext_kind(ext_kind),
    .scale_shift(scale_shift),
    .const_value(dec_const)
  );

  // registered copy for the next pipeline stage; same-cycle results stay above
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dec_valid_reg <= 1'b0;
      dec_format_reg <= `IFD_FMT_ZERO;
      dec_src_mode_reg <= `IFD_MODE_NONE;
      dec_dst_mode_reg <= `IFD_MODE_NONE;
      dec_src_idx_reg <= `IFD_INDEX_ZERO;
      dec_dst_idx_reg <= `IFD_INDEX_ZERO;
      dec_const_reg <= 32'h00000000;
      dec_size_reg <= `IFD_SIZE_BYTE;
      dec_illegal_reg <= 1'b0;
    end else begin
      dec_valid_reg <= instr_valid;
      if (instr_valid) begin
        dec_format_reg <= dec_format;
        dec_src_mode_reg <= dec_src_mode;
        dec_dst_mode_reg <= dec_dst_mode;
        dec_src_idx_reg <= source_reg_field;
        dec_dst_idx_reg <= destination_reg_field;
        dec_const_reg <= dec_const;
        dec_size_reg <= dec_size;
        dec_illegal_reg <= dec_illegal;
      end
    end
  end

endmodule

// ### ifd_defines.vh
`ifndef IFD_DEFINES_VH
`define IFD_DEFINES_VH

// instruction word span
`define IFD_WORD_MSB 15
`define IFD_WORD_LSB 0

// field positions
`define IFD_OP_MSB 15
`define IFD_OP_LSB 12
`define IFD_DST_MSB 11
`define IFD_DST_LSB 8
`define IFD_SRC_MSB 7
`define IFD_SRC_LSB 4
`define IFD_LOW_MSB 3
`define IFD_LOW_LSB 0

// layout codes
`define IFD_FMT_ZERO 4'h0
`define IFD_FMT_N 4'h1
`define IFD_FMT_M 4'h2
`define IFD_FMT_NM 4'h3
`define IFD_FMT_MD 4'h4
`define IFD_FMT_ND4 4'h5
`define IFD_FMT_NMD 4'h6
`define IFD_FMT_D 4'h7
`define IFD_FMT_D12 4'h8
`define IFD_FMT_ND8 4'h9
`define IFD_FMT_I 4'hA
`define IFD_FMT_NI 4'hB
`define IFD_FMT_BAD 4'hF

// operand addressing codes
`define IFD_MODE_NONE 4'h0
`define IFD_MODE_REG 4'h1
`define IFD_MODE_IND 4'h2
`define IFD_MODE_POSTINC 4'h3
`define IFD_MODE_PREDEC 4'h4
`define IFD_MODE_REG_DISP 4'h5
`define IFD_MODE_IDX_R0 4'h6
`define IFD_MODE_GBR_DISP 4'h7
`define IFD_MODE_IDX_GBR 4'h8
`define IFD_MODE_PC_DISP 4'h9
`define IFD_MODE_PC_REL 4'hA
`define IFD_MODE_PC_PLUS_REG 4'hB
`define IFD_MODE_IMM 4'hC
`define IFD_MODE_CTRL_SYS 4'hD
`define IFD_MODE_MAC_ACC 4'hE
`define IFD_MODE_R0 4'hF

// extension kinds of the constant field
`define IFD_EXT_NONE 3'h0
`define IFD_EXT_Z4 3'h1
`define IFD_EXT_Z8 3'h2
`define IFD_EXT_S8 3'h3
`define IFD_EXT_S12 3'h4

// operand sizes, also the left shift of the scaled constant
`define IFD_SIZE_BYTE 2'h0
`define IFD_SIZE_WORD 2'h1
`define IFD_SIZE_LONG 2'h2

`define IFD_INDEX_ZERO 4'h0

`endif

// ### ifd_field_extract.v
`timescale 1ns/10ps
`include "ifd_defines.vh"

module ifd_field_extract (
  input wire [15:0] instr_word,
  input wire [3:0] fmt,
  output reg [3:0] destination_reg_field,
  output reg [3:0] source_reg_field
);

  wire [3:0] hi_field;
  wire [3:0] mid_field;

  assign hi_field = instr_word[`IFD_DST_MSB:`IFD_DST_LSB];
  assign mid_field = instr_word[`IFD_SRC_MSB:`IFD_SRC_LSB];

  // operands that are implicitly the index register read as index zero
  always @* begin
    destination_reg_field = `IFD_INDEX_ZERO;
    source_reg_field = `IFD_INDEX_ZERO;
    case (fmt)
      `IFD_FMT_N, `IFD_FMT_ND8, `IFD_FMT_NI: begin
        destination_reg_field = hi_field;
      end
      // single-source layout keeps its field in the upper register slot
      `IFD_FMT_M: begin
        source_reg_field = hi_field;
      end
      `IFD_FMT_NM, `IFD_FMT_NMD: begin
        destination_reg_field = hi_field;
        source_reg_field = mid_field;
      end
      `IFD_FMT_MD: begin
        source_reg_field = mid_field;
      end
      `IFD_FMT_ND4: begin
        destination_reg_field = mid_field;
      end
      default: begin
        destination_reg_field = `IFD_INDEX_ZERO;
        source_reg_field = `IFD_INDEX_ZERO;
      end
    endcase
  end

endmodule

// ### ifd_disp_extend.v
`timescale 1ns/10ps
`include "ifd_defines.vh"

module ifd_disp_extend (
  input wire [15:0] instr_word,
  input wire [2:0] ext_kind,
  input wire [1:0] scale_shift,
  output wire [31:0] const_value
);

  function [31:0] extend_field;
    input [11:0] raw;
    input [2:0] kind;
    begin
      case (kind)
        `IFD_EXT_Z4: extend_field = {28'h0000000, raw[3:0]};
        `IFD_EXT_Z8: extend_field = {24'h000000, raw[7:0]};
        `IFD_EXT_S8: extend_field = {{24{raw[7]}}, raw[7:0]};
        `IFD_EXT_S12: extend_field = {{20{raw[11]}}, raw[11:0]};
        default: extend_field = 32'h00000000;
      endcase
    end
  endfunction

  wire [31:0] extended;

  assign extended = extend_field(instr_word[11:0], ext_kind);
  // scaling by 1, 2 or 4 is a left shift; the top bits drop on purpose
  assign const_value = extended << scale_shift;

endmodule

// ### ifd_decoder_sva.sv
`timescale 1ns/10ps
`include "ifd_defines.vh"

module ifd_decoder_sva (
  input wire clk_sys,
  input wire rst_n,
  input wire instr_valid,
  input wire [15:0] instr_word,
  input wire [3:0] dec_format,
  input wire [3:0] dec_src_mode,
  input wire [3:0] dec_dst_mode,
  input wire [3:0] source_reg_field,
  input wire [3:0] destination_reg_field,
  input wire [31:0] dec_const,
  input wire dec_illegal,
  input wire dec_valid_reg,
  input wire [3:0] dec_format_reg,
  input wire [31:0] dec_const_reg
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire [3:0] op = instr_word[15:12];
  wire [7:0] lo8 = instr_word[7:0];

  sequence s_word_in;
    instr_valid;
  endsequence
  sequence s_idle;
    !instr_valid;
  endsequence

  capture_word_a: assert property (s_word_in |=> dec_valid_reg && dec_format_reg == $past(dec_format)
    && dec_const_reg == $past(dec_const)) else $error("registered decode differs from word taken");
  hold_regs_a: assert property (s_idle |=> !dec_valid_reg && $stable(dec_format_reg)
    && $stable(dec_const_reg)) else $error("registered decode moved without a word");
  field_place_a: assert property (dec_format == `IFD_FMT_NM |-> destination_reg_field == instr_word[11:8]
    && source_reg_field == instr_word[7:4]) else $error("register fields taken from wrong bits");
  long_branch_a: assert property (op == 4'hA |-> dec_format == `IFD_FMT_D12
    && dec_const == {{19{instr_word[11]}}, instr_word[11:0], 1'b0}) else $error("long branch offset wrong");
  short_branch_a: assert property (instr_word[15:8] == 8'h89 |-> dec_dst_mode == `IFD_MODE_PC_REL
    && dec_const == {{23{lo8[7]}}, lo8, 1'b0}) else $error("short branch offset wrong");
  trap_scale_a: assert property (instr_word[15:8] == 8'hC3 |-> dec_format == `IFD_FMT_I
    && dec_const == {22'h0, lo8, 2'b00}) else $error("trap immediate not scaled by four");
  gbr_scale_a: assert property (instr_word[15:10] == 6'b110001 && instr_word[9:8] != 2'b11
    |-> dec_src_mode == `IFD_MODE_GBR_DISP && dec_const == ({24'h0, lo8} << instr_word[9:8]))
    else $error("base pointer displacement scaled wrong");
  mac_operands_a: assert property ((op == 4'h0 || op == 4'h4) && instr_word[3:0] == 4'hF
    |-> dec_src_mode == `IFD_MODE_POSTINC && dec_dst_mode == `IFD_MODE_MAC_ACC) else $error("accumulate operands wrong");
  far_branch_a: assert property (op == 4'h0 && instr_word[7:0] == 8'h23
    |-> dec_src_mode == `IFD_MODE_PC_PLUS_REG && source_reg_field == instr_word[11:8]) else $error("far branch wrong");
  illegal_word_a: assert property (op == 4'hF |-> dec_illegal && dec_format == `IFD_FMT_BAD
    && dec_const == 32'h00000000) else $error("unknown word not flagged");
endmodule

bind ifd_decoder ifd_decoder_sva i_sva (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .instr_valid(instr_valid),
  .instr_word(instr_word),
  .dec_format(dec_format),
  .dec_src_mode(dec_src_mode),
  .dec_dst_mode(dec_dst_mode),
  .source_reg_field(source_reg_field),
  .destination_reg_field(destination_reg_field),
  .dec_const(dec_const),
  .dec_illegal(dec_illegal),
  .dec_valid_reg(dec_valid_reg),
  .dec_format_reg(dec_format_reg),
  .dec_const_reg(dec_const_reg)
);

// ### ifd_fetch_model.sv
`timescale 1ns/10ps

module ifd_fetch_model (
  input wire clk_sys,
  input wire rst_n,
  input wire [15:0] req_word,
  input wire req_valid,
  output wire instr_valid,
  output wire [15:0] instr_word
);
  reg [15:0] last_reg;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      last_reg <= 16'h0000;
    else if (req_valid)
      last_reg <= req_word;
  end
  // idle slots show the complement so a stale word never looks valid
  assign instr_valid = req_valid;
  assign instr_word = req_valid ? req_word : ~last_reg;
endmodule

// ### instruction_format_decoder_tb.sv
`timescale 1ns/10ps
`include "ifd_defines.vh"

module instruction_format_decoder_tb;
  reg clk_sys = 1'b0;
  reg rst_n = 1'b0;
  reg [15:0] req_word = 16'h0000;
  reg req_valid = 1'b0;
  wire instr_valid, ill, vr, illr;
  wire [15:0] instr_word;
  wire [3:0] fm, sm, dm, si, di, fmr, smr, dmr, sir, dir;
  wire [31:0] c, cr;
  wire [1:0] sz, szr;
  integer n_errors = 0;
  integer total_checks = 0;
  integer seed = 87;
  integer i;
  reg [31:0] t;
  reg [15:0] w;
  reg [3:0] e_fm, e_sm, e_dm, e_si, e_di, cap_fm, cap_di, cap_sm, cap_dm, cap_si;
  reg [31:0] e_c, cap_c;
  reg [1:0] e_sz, cap_sz;
  reg [6:0] care, cap_care;
  reg e_ill, cap_v, cap_ill;

  always #5 clk_sys = ~clk_sys;

  ifd_fetch_model i_fetch (.clk_sys(clk_sys), .rst_n(rst_n), .req_word(req_word), .req_valid(req_valid),
    .instr_valid(instr_valid), .instr_word(instr_word));
  ifd_decoder i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .dec_format(fm), .dec_src_mode(sm), .dec_dst_mode(dm), .source_reg_field(si), .destination_reg_field(di),
    .dec_const(c), .dec_size(sz), .dec_illegal(ill), .dec_valid_reg(vr), .dec_format_reg(fmr),
    .dec_src_mode_reg(smr), .dec_dst_mode_reg(dmr), .dec_src_idx_reg(sir), .dec_dst_idx_reg(dir),
    .dec_const_reg(cr), .dec_size_reg(szr), .dec_illegal_reg(illr));

  task conclude;
    begin
      if (n_errors == 0 && total_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  task cmp4(input [3:0] exp, input [3:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
      end
    end
  endtask

  task cmp32(input [31:0] exp, input [31:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
      end
    end
  endtask

  // care bits: format, src mode, dst mode, src idx, dst idx, constant, size
  task put(input [3:0] f, input [3:0] s, input [3:0] d, input [6:0] m);
    begin
      e_fm = f;
      e_sm = s;
      e_dm = d;
      care = m;
    end
  endtask

  task predict(input [15:0] x);
    reg [31:0] z8, s8;
    begin
      z8 = {24'h0, x[7:0]};
      s8 = {{24{x[7]}}, x[7:0]};
      e_si = x[7:4];
      e_di = x[11:8];
      e_c = 32'h00000000;
      e_sz = x[9:8];
      e_ill = 1'b0;
      care = 7'h00;
      casez (x)
        16'hA???, 16'hB???: begin
          put(`IFD_FMT_D12, 4'h0, `IFD_MODE_PC_REL, 7'h52);
          e_c = {{19{x[11]}}, x[11:0], 1'b0};
        end
        16'h89??, 16'h8B??, 16'h8D??, 16'h8F??: begin
          put(`IFD_FMT_D, 4'h0, `IFD_MODE_PC_REL, 7'h52);
          e_c = s8 << 1;
        end
        16'hC0??, 16'hC1??, 16'hC2??: begin
          put(`IFD_FMT_D, `IFD_MODE_R0, `IFD_MODE_GBR_DISP, 7'h73);
          e_c = z8 << x[9:8];
        end
        16'hC3??: begin
          put(`IFD_FMT_I, 4'h0, 4'h0, 7'h42);
          e_c = z8 << 2;
        end
        16'hC4??, 16'hC5??, 16'hC6??: begin
          put(`IFD_FMT_D, `IFD_MODE_GBR_DISP, `IFD_MODE_R0, 7'h73);
          e_c = z8 << x[9:8];
        end
        16'hC7??: begin
          put(`IFD_FMT_D, `IFD_MODE_PC_DISP, `IFD_MODE_R0, 7'h72);
          e_c = z8 << 2;
        end
        16'b110010??????????: begin
          put(`IFD_FMT_I, 4'h0, `IFD_MODE_R0, 7'h52);
          e_c = z8;
        end
        16'b110011??????????: begin
          put(`IFD_FMT_I, 4'h0, `IFD_MODE_IDX_GBR, 7'h52);
          e_c = z8;
        end
        16'h7???, 16'hE???: begin
          put(`IFD_FMT_NI, 4'h0, `IFD_MODE_REG, 7'h56);
          e_c = s8;
        end
        16'h0??F, 16'h4??F: put(`IFD_FMT_NM, `IFD_MODE_POSTINC, `IFD_MODE_MAC_ACC, 7'h7C);
        16'h0?03, 16'h0?23: put(`IFD_FMT_M, `IFD_MODE_PC_PLUS_REG, 4'h0, 7'h68);
        16'h4?2B: put(`IFD_FMT_M, `IFD_MODE_IND, `IFD_MODE_NONE, 7'h78);
        16'h0??4, 16'h0??5: begin
          put(`IFD_FMT_NM, `IFD_MODE_REG, `IFD_MODE_IDX_R0, 7'h7D);
          e_sz = x[1:0];
        end
        16'h2??0, 16'h2??1: begin
          put(`IFD_FMT_NM, `IFD_MODE_REG, `IFD_MODE_IND, 7'h7D);
          e_sz = x[1:0];
        end
        16'h9???, 16'hD???: begin
          put(`IFD_FMT_ND8, `IFD_MODE_PC_DISP, `IFD_MODE_REG, 7'h77);
          e_sz = x[14] ? `IFD_SIZE_LONG : `IFD_SIZE_WORD;
          e_c = z8 << (x[14] ? 2 : 1);
        end
        16'h80??, 16'h81??: begin
          put(`IFD_FMT_ND4, `IFD_MODE_R0, `IFD_MODE_REG_DISP, 7'h77);
          e_di = x[7:4];
          e_c = {28'h0, x[3:0]} << x[8];
        end
        16'h1???, 16'h5???: begin
          put(`IFD_FMT_NMD, x[14] ? `IFD_MODE_REG_DISP : `IFD_MODE_REG,
            x[14] ? `IFD_MODE_REG : `IFD_MODE_REG_DISP, 7'h7E);
          e_c = {28'h0, x[3:0]} << 2;
        end
        16'h84??, 16'h85??: begin
          put(`IFD_FMT_MD, `IFD_MODE_REG_DISP, `IFD_MODE_R0, 7'h7B);
          e_c = {28'h0, x[3:0]} << x[8];
        end
        16'h4?03: put(`IFD_FMT_N, `IFD_MODE_CTRL_SYS, `IFD_MODE_PREDEC, 7'h74);
        16'h4?07: put(`IFD_FMT_M, `IFD_MODE_POSTINC, `IFD_MODE_CTRL_SYS, 7'h78);
        16'hF???: begin
          put(`IFD_FMT_BAD, `IFD_MODE_NONE, `IFD_MODE_NONE, 7'h72);
          e_ill = 1'b1;
        end
        default: care = 7'h00;
      endcase
      // single-source layout carries its register in the upper field
      if (e_fm == `IFD_FMT_M)
        e_si = x[11:8];
    end
  endtask

  task check_comb;
    begin
      if (care[6]) cmp4(e_fm, fm);
      if (care[5]) cmp4(e_sm, sm);
      if (care[4]) cmp4(e_dm, dm);
      if (care[3]) cmp4(e_si, si);
      if (care[2]) cmp4(e_di, di);
      if (care[1]) cmp32(e_c, c);
      if (care[0]) cmp4({2'b00, e_sz}, {2'b00, sz});
      if (care != 7'h00) cmp4({3'b000, e_ill}, {3'b000, ill});
    end
  endtask

  task step(input [15:0] x, input v);
    begin
      @(posedge clk_sys);
      req_word <= x;
      req_valid <= v;
      #1;
      cmp4({3'b000, cap_v}, {3'b000, vr});
      if (cap_care[6]) cmp4(cap_fm, fmr);
      if (cap_care[1]) cmp32(cap_c, cr);
      if (cap_care[2]) cmp4(cap_di, dir);
      if (cap_care[5]) cmp4(cap_sm, smr);
      if (cap_care[4]) cmp4(cap_dm, dmr);
      if (cap_care[3]) cmp4(cap_si, sir);
      if (cap_care[0]) cmp4({2'b00, cap_sz}, {2'b00, szr});
      if (cap_care != 7'h00) cmp4({3'b000, cap_ill}, {3'b000, illr});
      cap_v = v;
      if (v) begin
        predict(x);
        check_comb;
        cap_care = care;
        cap_fm = e_fm;
        cap_c = e_c;
        cap_di = e_di;
        cap_sm = e_sm;
        cap_dm = e_dm;
        cap_si = e_si;
        cap_sz = e_sz;
        cap_ill = e_ill;
      end
    end
  endtask

  // reset clears the registered copy; capture state is seeded with zeros and every care bit set
  task do_reset(input integer n);
    begin
      @(posedge clk_sys);
      rst_n <= 1'b0;
      // a word left standing would be captured at the first edge after release
      req_valid <= 1'b0;
      repeat (n) @(posedge clk_sys);
      #1;
      cmp4(4'h0, {3'b000, vr});
      cmp32(32'h00000000, cr);
      cap_v = 1'b0;
      cap_care = 7'h7F;
      cap_fm = 4'h0;
      cap_c = 32'h00000000;
      cap_di = 4'h0;
      cap_sm = 4'h0;
      cap_dm = 4'h0;
      cap_si = 4'h0;
      cap_sz = 2'h0;
      cap_ill = 1'b0;
      @(posedge clk_sys);
      rst_n <= 1'b1;
    end
  endtask

  function [31:0] tpl(input integer k);
    case (k)
      0: tpl = 32'hA0001FFF;
      1: tpl = 32'h890006FF;
      2: tpl = 32'hC0000FFF;
      3: tpl = 32'h70000FFF;
      4: tpl = 32'hE0000FFF;
      5: tpl = 32'h000F0FF0;
      6: tpl = 32'h400F0FF0;
      7: tpl = 32'h00030F20;
      8: tpl = 32'h402B0F00;
      9: tpl = 32'h00040FF1;
      10: tpl = 32'h20000FF1;
      11: tpl = 32'h840001FF;
      12: tpl = 32'hF0000FFF;
      13: tpl = 32'h40030F00;
      14: tpl = 32'h90004FFF;
      15: tpl = 32'h800001FF;
      16: tpl = 32'h10004FFF;
      default: tpl = 32'h40070F00;
    endcase
  endfunction

  initial begin
    #100000;
    n_errors = n_errors + 1;
    conclude;
  end

  initial begin
    do_reset(6);
    for (i = 0; i < 400; i = i + 1) begin
      if (i == 300)
        do_reset(2);
      t = tpl($unsigned($random(seed)) % 18);
      w = t[31:16] | (t[15:0] & $random(seed));
      step(w, ($random(seed) & 3) != 0);
    end
    step(16'h0000, 1'b0);
    conclude;
  end
endmodule
